// ### include/mas_pkg.sv
// Constants for the monitor ADC sequencer
// How it works
// - Voltage results are compared with high/low limits; status bit 1 means out-of-limit.
// - Alert output asserts once an enabled limit-violation status bit is set.
// - Battery divider lower leg connects only while the battery channel is converted.
// - Channels are converted one after another in a repeating round-robin order.
// - Temperature and voltage results are the average of 16 conversions.
// - Battery channel is converted once, no averaging, in a 711 us slot.
// - Slot times are 9.01 ms local, 38.36 ms remote, 8.53 ms voltage.
// - Fan speed pulse inputs take no slot in the conversion sequence.
// - A set bypass bit in either bypass register routes that pin straight to ADC.
// - Bit 2 of the single-channel control register selects single-channel mode.
// - In single-channel mode only the channel in bits 7 to 3 is converted.
// - Channel codes 0 battery, 1-3 remote, 4 local, 5-14 and 16-17 voltages.
// - Single-channel mode repeats conversions on the selected channel continuously.
// - Results are 10 bits, nominal input gives code 768.
// - Status bit stays set until read, then clears only if condition has gone.
package mas_pkg;
  localparam logic [7:0] ADDR_SINGLE    = 8'h16;
  localparam logic [7:0] ADDR_BYPASS1   = 8'h18;
  localparam logic [7:0] ADDR_BYPASS2   = 8'h19;
  localparam logic [7:0] RST_SINGLE     = 8'h00;
  localparam logic [7:0] RST_BYPASS     = 8'h00;
  localparam int         SINGLE_EN_BIT  = 2;
  localparam int         SEL_LSB        = 3;
  localparam int         NUM_CHAN       = 18;
  localparam logic [4:0] CHAN_BATT      = 5'h00;
  localparam logic [4:0] CHAN_REM_FIRST = 5'h01;
  localparam logic [4:0] CHAN_REM_LAST  = 5'h03;
  localparam logic [4:0] CHAN_LOCAL     = 5'h04;
  localparam logic [4:0] CHAN_UNUSED    = 5'h0f;
  localparam logic [4:0] CHAN_LAST      = 5'h11;
  localparam int         RES_W          = 10;
  localparam logic [9:0] RES_NOMINAL    = 10'h300;
  localparam logic [4:0] AVG_COUNT      = 5'h10;
  localparam logic [4:0] BATT_COUNT     = 5'h01;
  localparam int         AVG_SHIFT      = 4;
  localparam int         CLK_PERIOD_NS  = 5;
  localparam int         T_LOCAL_NS     = 9010000;
  localparam int         T_REMOTE_NS    = 38360000;
  localparam int         T_VOLT_NS      = 8530000;
  localparam int         T_BATT_NS      = 711000;
  localparam int         CYC_LOCAL      = T_LOCAL_NS / CLK_PERIOD_NS;
  localparam int         CYC_REMOTE     = T_REMOTE_NS / CLK_PERIOD_NS;
  localparam int         CYC_VOLT       = T_VOLT_NS / CLK_PERIOD_NS;
  localparam int         CYC_BATT       = T_BATT_NS / CLK_PERIOD_NS;
endpackage : mas_pkg

// ### rtl/mas_avg.sv
// Sample accumulator that averages conversions
`timescale 1ns/10ps
`default_nettype none
module mas_avg #(
  parameter int RES_W = 10,
  parameter int SHIFT = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             add,
  input  wire logic [RES_W-1:0] sample,
  output logic      [RES_W-1:0] avg
);
  logic [RES_W+SHIFT-1:0] acc_r;
  logic [RES_W+SHIFT-1:0] sum;

  // Running sum with the sample now on the input, so the last sample counts at once
  assign sum = acc_r + {{SHIFT{1'b0}}, sample};

  // Sum of samples since the last clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
    end else if (clr) begin
      acc_r <= '0;
    end else if (add) begin
      acc_r <= sum;
    end
  end

  // Division by a power of two
  assign avg = sum[RES_W+SHIFT-1:SHIFT];
endmodule : mas_avg
`default_nettype wire

// ### rtl/mas_seq.sv
// Round-robin and single-channel sequencer for the monitor ADC
`timescale 1ns/10ps
`default_nettype none
module mas_seq #(
  parameter int unsigned CYC_LOCAL  = mas_pkg::CYC_LOCAL,
  parameter int unsigned CYC_REMOTE = mas_pkg::CYC_REMOTE,
  parameter int unsigned CYC_VOLT   = mas_pkg::CYC_VOLT,
  parameter int unsigned CYC_BATT   = mas_pkg::CYC_BATT
) (
  input  wire logic                            CLK_SYS,
  input  wire logic                            RESET,
  input  wire logic [7:0]                      REG_ADDR,
  input  wire logic [7:0]                      REG_WDATA,
  input  wire logic                            REG_WR,
  input  wire logic                            REG_RD,
  output logic      [7:0]                      REG_RDATA,
  input  wire logic [mas_pkg::NUM_CHAN-1:0]    CHAN_ENABLE,
  input  wire logic [mas_pkg::NUM_CHAN*8-1:0]  LIMIT_HIGH,
  input  wire logic [mas_pkg::NUM_CHAN*8-1:0]  LIMIT_LOW,
  input  wire logic [mas_pkg::NUM_CHAN-1:0]    ALERT_ENABLE,
  input  wire logic                            STATUS_READ,
  output logic      [mas_pkg::NUM_CHAN-1:0]    STATUS,
  output logic                                 ALERT_N,
  output logic      [4:0]                      ADC_CHAN,
  output logic                                 ADC_START,
  input  wire logic                            ADC_DONE,
  input  wire logic [mas_pkg::RES_W-1:0]       ADC_DATA,
  output logic                                 BATT_DIV_CONNECT,
  output logic      [15:0]                     DIV_BYPASS,
  output logic      [mas_pkg::RES_W-1:0]       RESULT_DATA,
  output logic      [4:0]                      RESULT_CHAN,
  output logic                                 RESULT_VALID
);
  typedef enum logic [1:0] {S_PICK, S_CONV, S_WAIT, S_HOLD} mas_state_t;

  mas_state_t                      st_r, st_nxt;
  logic [7:0]                      single_r, byp1_r, byp2_r;
  logic [4:0]                      chan_r, pick_chan, samp_r, n_start_r;
  logic                            pick_ok;
  logic [31:0]                     tmr_r;
  logic                            last_samp, publish;
  logic [mas_pkg::RES_W-1:0]       avg, result;
  logic [mas_pkg::NUM_CHAN-1:0]    status_r, cond_r, status_nxt, cond_nxt;
  logic                            oor;
  logic                            single_mode;
  logic [4:0]                      sel;

  // Classifiers for channel codes
  function automatic logic is_valid(input logic [4:0] c);
    return (c <= mas_pkg::CHAN_LAST) && (c != mas_pkg::CHAN_UNUSED);
  endfunction : is_valid

  function automatic logic is_volt(input logic [4:0] c);
    return is_valid(c) && (c == mas_pkg::CHAN_BATT || c > mas_pkg::CHAN_LOCAL);
  endfunction : is_volt

  function automatic logic [31:0] slot_len(input logic [4:0] c);
    if (c == mas_pkg::CHAN_BATT) return 32'(CYC_BATT);
    if (c == mas_pkg::CHAN_LOCAL) return 32'(CYC_LOCAL);
    if (c >= mas_pkg::CHAN_REM_FIRST && c <= mas_pkg::CHAN_REM_LAST) return 32'(CYC_REMOTE);
    return 32'(CYC_VOLT);
  endfunction : slot_len

  assign single_mode = single_r[mas_pkg::SINGLE_EN_BIT];
  assign sel         = single_r[mas_pkg::SEL_LSB+4:mas_pkg::SEL_LSB];

  // Next channel: the select code in single mode, else next enabled analog code after the current one, wrapping
  always_comb begin
    logic [4:0] c;
    c         = chan_r;
    pick_chan = chan_r;
    pick_ok   = 1'b0;
    if (single_mode) begin
      pick_chan = sel;
      pick_ok   = is_valid(sel);
    end else begin
      // Only ADC codes exist here; fan speed pulse inputs never get a slot
      for (int i = 0; i < mas_pkg::NUM_CHAN; i++) begin
        c = (c >= mas_pkg::CHAN_LAST) ? 5'h00 : 5'(c + 5'h01);
        if (!pick_ok && is_valid(c) && CHAN_ENABLE[c]) begin
          pick_chan = c;
          pick_ok   = 1'b1;
        end
      end
    end
  end

  assign last_samp = (st_r == S_WAIT) && ADC_DONE &&
                     (samp_r == ((chan_r == mas_pkg::CHAN_BATT) ? mas_pkg::BATT_COUNT : mas_pkg::AVG_COUNT));
  assign publish   = last_samp;

  // Sequencer state transitions
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_PICK: if (pick_ok) st_nxt = S_CONV;
      S_CONV: st_nxt = S_WAIT;
      S_WAIT: if (ADC_DONE) st_nxt = last_samp ? S_HOLD : S_CONV;
      S_HOLD: if (tmr_r <= 32'h1) st_nxt = S_PICK;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) st_r <= S_PICK;
    else       st_r <= st_nxt;
  end

  // Channel latch and slot timer
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      chan_r <= mas_pkg::CHAN_LAST;
      tmr_r  <= 32'h0;
    end else if (st_r == S_PICK && pick_ok) begin
      chan_r <= pick_chan;
      tmr_r  <= slot_len(pick_chan) - 32'h1;
    end else if (tmr_r != 32'h0) begin
      tmr_r  <= tmr_r - 32'h1;
    end
  end

  // Samples taken in the current slot
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) samp_r <= 5'h00;
    else if (st_r == S_PICK) samp_r <= 5'h00;
    else if (st_r == S_CONV) samp_r <= 5'(samp_r + 5'h01);
  end

  // Start pulses issued in the current slot, counted apart from the sequencer for the checks
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) n_start_r <= 5'h00;
    else if (st_r == S_PICK) n_start_r <= 5'h00;
    else if (ADC_START) n_start_r <= 5'(n_start_r + 5'h01);
  end

  // Conversion start pulse and mux select
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ADC_START <= 1'b0;
      ADC_CHAN  <= 5'h00;
    end else begin
      ADC_START <= (st_nxt == S_CONV);
      ADC_CHAN  <= (st_r == S_PICK && pick_ok) ? pick_chan : chan_r;
    end
  end

  mas_avg #(
    .RES_W (mas_pkg::RES_W),
    .SHIFT (mas_pkg::AVG_SHIFT)
  ) u_avg (
    .clk    (CLK_SYS),
    .rst    (RESET),
    .clr    (st_r == S_PICK),
    .add    (st_r == S_WAIT && ADC_DONE),
    .sample (ADC_DATA),
    .avg    (avg)
  );

  assign result = (chan_r == mas_pkg::CHAN_BATT) ? ADC_DATA : avg;
  assign oor    = (result[9:2] > LIMIT_HIGH[chan_r*8 +: 8]) || (result[9:2] < LIMIT_LOW[chan_r*8 +: 8]);

  // Result outputs
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      RESULT_DATA  <= '0;
      RESULT_CHAN  <= 5'h00;
      RESULT_VALID <= 1'b0;
    end else begin
      RESULT_VALID <= publish;
      if (publish) begin
        RESULT_DATA <= result;
        RESULT_CHAN <= chan_r;
      end
    end
  end

  // Limit status: set wins over the clearing read
  always_comb begin
    cond_nxt   = cond_r;
    status_nxt = status_r;
    if (STATUS_READ) status_nxt = status_r & cond_r;
    if (publish && is_volt(chan_r)) begin
      cond_nxt[chan_r] = oor;
      if (oor) status_nxt[chan_r] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      status_r <= '0;
      cond_r   <= '0;
      ALERT_N  <= 1'b1;
    end else begin
      status_r <= status_nxt;
      cond_r   <= cond_nxt;
      ALERT_N  <= ~|(status_nxt & ALERT_ENABLE);
    end
  end

  assign STATUS = status_r;

  // Battery divider connected only through the battery conversion
  assign BATT_DIV_CONNECT = (chan_r == mas_pkg::CHAN_BATT) && (st_r == S_CONV || st_r == S_WAIT);

  // Register writes; host keeps pin setup still in single mode
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      single_r <= mas_pkg::RST_SINGLE;
      byp1_r   <= mas_pkg::RST_BYPASS;
      byp2_r   <= mas_pkg::RST_BYPASS;
    end else if (REG_WR) begin
      if (REG_ADDR == mas_pkg::ADDR_SINGLE)  single_r <= REG_WDATA;
      if (REG_ADDR == mas_pkg::ADDR_BYPASS1) byp1_r   <= REG_WDATA;
      if (REG_ADDR == mas_pkg::ADDR_BYPASS2) byp2_r   <= REG_WDATA;
    end
  end

  assign DIV_BYPASS = {byp2_r, byp1_r};

  // Register reads, unmapped read as zero
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        mas_pkg::ADDR_SINGLE:  REG_RDATA <= single_r;
        mas_pkg::ADDR_BYPASS1: REG_RDATA <= byp1_r;
        mas_pkg::ADDR_BYPASS2: REG_RDATA <= byp2_r;
        default:               REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence conv_slot_start;
    st_r == S_PICK && pick_ok;
  endsequence

  a_batt_conn_only: assert property (BATT_DIV_CONNECT |-> ADC_CHAN == mas_pkg::CHAN_BATT && !RESULT_VALID)
    else $error("battery divider connected outside battery conversion");
  a_single_sel: assert property (conv_slot_start ##0 single_mode |=> chan_r == $past(sel))
    else $error("single mode converted wrong channel");
  a_rr_enabled: assert property (conv_slot_start ##0 !single_mode |-> CHAN_ENABLE[pick_chan])
    else $error("disabled channel entered sequence");
  a_avg_sixteen: assert property (publish && chan_r != mas_pkg::CHAN_BATT |-> n_start_r == mas_pkg::AVG_COUNT)
    else $error("average not over sixteen samples");
  a_batt_single: assert property (publish && chan_r == mas_pkg::CHAN_BATT |-> n_start_r == mas_pkg::BATT_COUNT)
    else $error("battery converted more than once");
  a_status_set: assert property (publish && is_volt(chan_r) && oor |=> STATUS[$past(chan_r)])
    else $error("out-of-limit result did not set status");
  a_status_sticky: assert property (|($past(status_r) & ~status_r) |-> $past(STATUS_READ))
    else $error("status cleared without a read");
  a_alert_on: assert property (|(status_r & ALERT_ENABLE) && $stable(ALERT_ENABLE) |-> !ALERT_N)
    else $error("alert missing for enabled status");
  a_hold_timer: assert property (st_r == S_HOLD ##1 st_r == S_PICK |-> tmr_r == 32'h0)
    else $error("slot ended before its time");
  a_bypass_write: assert property (REG_WR && REG_ADDR == 8'h18 |=> DIV_BYPASS[7:0] == $past(REG_WDATA))
    else $error("bypass register write lost");
endmodule : mas_seq
`default_nettype wire

// ### bench/mas_adc_model.sv
// Behavioural ADC that answers each start pulse with a per-channel level
`timescale 1ns/10ps
`default_nettype none
module mas_adc_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [4:0]   chan,
  input  wire logic [7:0]   dly,
  input  wire logic [179:0] level,
  output logic              done,
  output logic [9:0]        data
);
  logic [7:0] cnt_r;
  logic       tog_r;
  // Count down the latency, then return the level; bit 4 alternates except on the battery input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      tog_r <= 1'b0;
      done  <= 1'b0;
      data  <= 10'h000;
    end else begin
      done <= 1'b0;
      data <= ~data; // Data is meaningless outside the done cycle
      if (start) begin
        cnt_r <= dly;
      end else if (cnt_r == 8'h01) begin
        cnt_r <= 8'h00;
        done  <= 1'b1;
        tog_r <= ~tog_r;
        data  <= level[chan*10 +: 10] ^ ((chan != 5'h00 && tog_r) ? 10'h010 : 10'h000);
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : mas_adc_model
`default_nettype wire

// ### bench/tb_mas_seq.sv
// Self-checking bench for the monitor ADC sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_mas_seq;
  localparam int C_LOC = 200, C_REM = 400, C_VOLT = 150, C_BATT = 40;
  logic         clk_sys, reset, reg_wr, reg_rd, status_read, alert_n, adc_start, adc_done, batt_div, res_valid;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, adc_dly, rdv;
  logic [17:0]  chan_en, alert_en, status;
  logic [143:0] lim_hi, lim_lo;
  logic [4:0]   adc_chan, res_chan, rc;
  logic [9:0]   adc_data, res_data, rdat;
  logic [15:0]  div_bypass;
  logic [179:0] level;
  int           err_total, num_checks, n_div, n_leak, cyc, tot;

  mas_seq #(.CYC_LOCAL(C_LOC), .CYC_REMOTE(C_REM), .CYC_VOLT(C_VOLT), .CYC_BATT(C_BATT)) u_mas_seq (
    .CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CHAN_ENABLE(chan_en), .LIMIT_HIGH(lim_hi), .LIMIT_LOW(lim_lo),
    .ALERT_ENABLE(alert_en), .STATUS_READ(status_read), .STATUS(status), .ALERT_N(alert_n),
    .ADC_CHAN(adc_chan), .ADC_START(adc_start), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .BATT_DIV_CONNECT(batt_div), .DIV_BYPASS(div_bypass), .RESULT_DATA(res_data), .RESULT_CHAN(res_chan),
    .RESULT_VALID(res_valid));
  mas_adc_model u_mas_adc_model (.clk(clk_sys), .rst(reset), .start(adc_start), .chan(adc_chan),
    .dly(adc_dly), .level(level), .done(adc_done), .data(adc_data));

  // Clock at 200 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Compare one value and count it
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Print counts and verdict, then stop
  task results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Register write and read strobes, one cycle each
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  // Wait for the next result, watching the battery divider on the way
  task wait_res(output logic [4:0] c, output logic [9:0] d, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (batt_div === 1'b1) n_div++;
      if (adc_start === 1'b1 && adc_chan !== 5'h00 && batt_div !== 1'b0) n_leak++;
    end while (res_valid !== 1'b1 && n < 2000);
    chk("result valid", 16'h1, {15'h0, res_valid});
    chk("divider at result", 16'h0, {15'h0, batt_div});
    c = res_chan;
    d = res_data;
  endtask : wait_res

  // Reset values, bypass registers and an unmapped address
  task t_regs;
    logic [7:0] ad [3];
    ad = '{8'h16, 8'h18, 8'h19};
    foreach (ad[i]) begin
      rd(ad[i], rdv);
      chk("reset value", 16'h0, {8'h0, rdv});
    end
    wr(8'h18, 8'ha5);
    wr(8'h19, 8'h3c);
    wr(8'h17, 8'hff);
    rd(8'h18, rdv);
    chk("bypass one", 16'ha5, {8'h0, rdv});
    rd(8'h19, rdv);
    chk("bypass two", 16'h3c, {8'h0, rdv});
    rd(8'h17, rdv);
    chk("unmapped", 16'h0, {8'h0, rdv});
    chk("divider bypass", 16'h3ca5, div_bypass);
  endtask : t_regs

  // Every valid select code in single-channel mode, two repeated results each
  task t_single;
    for (int k = 0; k < 18; k++) begin
      if (k == 15) continue;
      wr(8'h16, {k[4:0], 3'b100});
      n_div = 0;
      for (int j = 0; j < 3; j++) begin
        wait_res(rc, rdat, cyc);
        if (j == 0) continue;
        chk("single chan", {11'h0, k[4:0]}, {11'h0, rc});
        chk("single data", (k == 0) ? 16'h300 : 16'h308, {6'h0, rdat});
      end
      if (k == 0) chk("divider used", 16'h1, {15'h0, n_div != 0});
    end
    rd(8'h16, rdv);
    chk("single reg", 16'h8c, {8'h0, rdv});
  endtask : t_single

  // Limit comparison, alert and sticky status cleared by a read
  task t_status;
    adc_dly = 8'h01;
    wr(8'h16, 8'h2c);
    lim_hi[47:40] = 8'hc0;
    alert_en[5] = 1'b1;
    wait_res(rc, rdat, cyc);
    wait_res(rc, rdat, cyc);
    chk("status high", 16'h1, {15'h0, status[5]});
    chk("alert", 16'h0, {15'h0, alert_n});
    @(negedge clk_sys) status_read = 1'b1;
    @(negedge clk_sys) status_read = 1'b0;
    chk("status kept", 16'h1, {15'h0, status[5]});
    lim_hi[47:40] = 8'hff;
    wait_res(rc, rdat, cyc);
    @(negedge clk_sys) status_read = 1'b1;
    @(negedge clk_sys) status_read = 1'b0;
    chk("status cleared", 16'h0, {15'h0, status[5]});
    chk("alert released", 16'h1, {15'h0, alert_n});
    lim_lo[47:40] = 8'hc3;
    wait_res(rc, rdat, cyc);
    chk("status low", 16'h1, {15'h0, status[5]});
  endtask : t_status

  // Round robin over three enabled channels and its period
  task t_rr;
    wr(8'h16, 8'h00);
    chan_en = 18'h00091;
    adc_dly = 8'h04;
    n_leak = 0;
    for (int i = 0; i < 6; i++) begin
      wait_res(rc, rdat, cyc);
      if (rc === 5'h00) break;
    end
    tot = 0;
    for (int i = 0; i < 3; i++) begin
      wait_res(rc, rdat, cyc);
      tot += cyc;
      chk("rr order", (i == 0) ? 16'h4 : (i == 1) ? 16'h7 : 16'h0, {11'h0, rc});
    end
    chk("rr period", C_BATT + C_LOC + C_VOLT, tot[15:0]);
    chk("divider leak", 16'h0, n_leak[15:0]);
  endtask : t_rr

  // Main sequence
  initial begin
    {reg_wr, reg_rd, status_read, reg_addr, reg_wdata} = '0;
    {err_total, num_checks, n_div, n_leak} = '0;
    chan_en = '1;
    alert_en = '0;
    lim_hi = {18{8'hff}};
    lim_lo = '0;
    level = {18{10'h300}};
    adc_dly = 8'h04;
    reset = 1'b1;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    t_regs;
    t_single;
    t_status;
    t_rr;
    results;
  end

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    results;
  end
endmodule : tb_mas_seq
`default_nettype wire
